/* logic/sar_support.sv */
// ==========================================================================
// shared constants and types
// ==========================================================================
package sar_pkg;

    // result word geometry
    localparam int unsigned RESULT_WIDTH = 14;
    localparam logic [3:0]  MSB_INDEX    = 4'hd;
    localparam logic [3:0]  LSB_INDEX    = 4'h0;

    // clock and bit trial timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned BIT_TIME_NS   = 24;
    localparam int unsigned BIT_CYCLES_INT =
        (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BIT_CNT_WIDTH = 2;
    localparam logic [BIT_CNT_WIDTH-1:0] BIT_CYCLES_LAST =
        BIT_CNT_WIDTH'(BIT_CYCLES_INT - 1);
    localparam logic [BIT_CNT_WIDTH-1:0] BIT_CNT_RESET = 2'h0;

    // least acquisition interval the host leaves between conversions
    localparam int unsigned ACQ_MIN_NS = 70;
    localparam int unsigned ACQ_MIN_CYCLES =
        (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // reset values and the msb trial word
    localparam logic [RESULT_WIDTH-1:0] WORD_ZERO    = 14'h0000;
    localparam logic [RESULT_WIDTH-1:0] WORD_MSB_BIT = 14'h2000;
    localparam logic                    BUSY_N_IDLE  = 1'b1;
    localparam logic                    TRACK_ON     = 1'b1;
    localparam logic                    START_N_IDLE = 1'b1;

    // sequencer states
    typedef enum logic [1:0] {
        ST_ACQUIRE,
        ST_CLEAR,
        ST_TRIAL
    } conv_state_t;

endpackage

// ==========================================================================
// internal bit clock: one tick per bit trial while running
// ==========================================================================
module bit_tick_divider (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);

    logic [sar_pkg::BIT_CNT_WIDTH-1:0] cnt_reg;
    logic [sar_pkg::BIT_CNT_WIDTH-1:0] cnt_next;
    logic                              tick_reg;
    logic                              tick_next;

    // count bit periods, restart whenever run drops
    always_comb begin
        cnt_next  = sar_pkg::BIT_CNT_RESET;
        tick_next = 1'b0;
        if (run) begin
            if (cnt_reg == sar_pkg::BIT_CYCLES_LAST) begin
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    // register counter and tick
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= sar_pkg::BIT_CNT_RESET;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg & run;

endmodule

/* logic/sar_conversion_sequencer.sv */
// Operation
// - a conversion starts only when the host asks for it on conversion_start_n.
// - conversion_start_n is active low and its falling edge starts a conversion.
// - the approximation register is cleared before the first bit trial.
// - start requests during a running conversion are ignored and never restart it.
// - busy_n is low while a conversion runs and high otherwise.
// - the 14-bit result is resolved one bit at a time from msb down to lsb.
// - at the end the finished approximation word is loaded into the output latches.
// - the latched word is the difference of the positive and negative inputs.
// - bit trials are timed by an internal clock, the host supplies none.
// - both inputs are captured at one common instant as conversion begins.
// - the acquire phase resumes at the end of each conversion.
// - result data is valid at the moment busy_n rises, within 20ns.
module sar_conversion_sequencer (
    input  wire logic                             sys_clk,
    input  wire logic                             rst_n,
    input  wire logic                             conversion_start_n,
    input  wire logic                             cmp_keep,
    output logic                                  busy_n,
    output logic [sar_pkg::RESULT_WIDTH-1:0]      result_data,
    output logic [sar_pkg::RESULT_WIDTH-1:0]      dac_code,
    output logic                                  track
);

    // ======================================================================
    // declarations
    // ======================================================================
    sar_pkg::conv_state_t                 state_reg;
    sar_pkg::conv_state_t                 state_next;
    logic [3:0]                           bit_idx_reg;
    logic [3:0]                           bit_idx_next;
    logic [sar_pkg::RESULT_WIDTH-1:0]     sar_reg;
    logic [sar_pkg::RESULT_WIDTH-1:0]     sar_next;
    logic [sar_pkg::RESULT_WIDTH-1:0]     result_reg;
    logic [sar_pkg::RESULT_WIDTH-1:0]     result_next;
    logic [sar_pkg::RESULT_WIDTH-1:0]     dac_code_reg;
    logic [sar_pkg::RESULT_WIDTH-1:0]     dac_code_next;
    logic                                 busy_n_reg;
    logic                                 busy_n_next;
    logic                                 track_reg;
    logic                                 track_next;
    logic                                 start_n_prev_reg;
    logic                                 start_n_prev_next;
    logic                                 start_fall;
    logic                                 trial_run;
    logic                                 bit_tick;
    logic [sar_pkg::RESULT_WIDTH-1:0]     trial_word;
    logic [sar_pkg::RESULT_WIDTH-1:0]     decided_word;
    logic                                 start_accept;
    logic                                 clear_phase;
    logic                                 last_bit;
    logic                                 conv_done;
    logic                                 bit_step;
    logic [3:0]                           lower_bit_idx;
    logic [sar_pkg::RESULT_WIDTH-1:0]     lower_trial_word;

    // ======================================================================
    // start edge detection
    // ======================================================================

    // remember last start level
    always_comb begin
        start_n_prev_next = conversion_start_n;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_n_prev_reg <= sar_pkg::START_N_IDLE;
        end else begin
            start_n_prev_reg <= start_n_prev_next;
        end
    end

    // high-to-low step of the start input
    assign start_fall = start_n_prev_reg & ~conversion_start_n;

    // ======================================================================
    // internal bit clock
    // ======================================================================

    // bit timing runs only in the trial phase, needs no host clock
    assign trial_run = (state_reg == sar_pkg::ST_TRIAL);

    bit_tick_divider u_bit_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (trial_run),
        .tick    (bit_tick)
    );

    // ======================================================================
    // bit trial arithmetic
    // ======================================================================

    // current trial: decided bits plus the bit under test
    assign trial_word = sar_reg | (sar_pkg::WORD_MSB_BIT >> (sar_pkg::MSB_INDEX - bit_idx_reg));

    // keep the trial bit when the held difference charge reaches the dac
    assign decided_word = cmp_keep ? trial_word : sar_reg;

    // ======================================================================
    // sequencer decode
    // ======================================================================

    // a start is taken only from acquire, edges while busy are dropped
    assign start_accept = (state_reg == sar_pkg::ST_ACQUIRE) & start_fall;

    // one cycle that empties the register before the msb trial
    assign clear_phase = (state_reg == sar_pkg::ST_CLEAR);

    // index on the lsb, the next tick ends the conversion
    assign last_bit = (bit_idx_reg == sar_pkg::LSB_INDEX);

    // a tick on the lsb finishes, any other tick steps one bit down
    assign conv_done = bit_tick & last_bit;
    assign bit_step  = bit_tick & ~last_bit;

    // next lower bit and its trial weight, used only on a step
    assign lower_bit_idx    = bit_idx_reg - 4'h1;
    assign lower_trial_word = sar_pkg::WORD_MSB_BIT >> (sar_pkg::MSB_INDEX - lower_bit_idx);

    // ======================================================================
    // conversion phase
    // ======================================================================

    // acquire, clear, then trials until the lsb tick
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            sar_pkg::ST_ACQUIRE: begin
                // only a host edge leaves acquire
                if (start_fall) begin
                    state_next = sar_pkg::ST_CLEAR;
                end
            end
            sar_pkg::ST_CLEAR: begin
                // empty register, arm the msb trial
                state_next = sar_pkg::ST_TRIAL;
            end
            sar_pkg::ST_TRIAL: begin
                // start edges here are not looked at
                if (conv_done) begin
                    state_next = sar_pkg::ST_ACQUIRE;
                end
            end
        endcase
    end

    // register the phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= sar_pkg::ST_ACQUIRE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ======================================================================
    // bit index
    // ======================================================================

    // msb armed in clear, one bit lower on each step
    always_comb begin
        bit_idx_next = bit_idx_reg;
        if (clear_phase) begin
            bit_idx_next = sar_pkg::MSB_INDEX;
        end else if (bit_step) begin
            bit_idx_next = lower_bit_idx;
        end
    end

    // register the bit index
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_idx_reg <= sar_pkg::MSB_INDEX;
        end else begin
            bit_idx_reg <= bit_idx_next;
        end
    end

    // ======================================================================
    // approximation register
    // ======================================================================

    // cleared before the msb trial, then every decision is kept
    always_comb begin
        sar_next = sar_reg;
        if (clear_phase) begin
            sar_next = sar_pkg::WORD_ZERO;
        end else if (bit_tick) begin
            sar_next = decided_word;
        end
    end

    // register the approximation word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sar_reg <= sar_pkg::WORD_ZERO;
        end else begin
            sar_reg <= sar_next;
        end
    end

    // ======================================================================
    // dac trial word
    // ======================================================================

    // msb first, next lower bit goes on the dac right after each decision
    always_comb begin
        dac_code_next = dac_code_reg;
        if (clear_phase) begin
            dac_code_next = sar_pkg::WORD_MSB_BIT;
        end else if (conv_done) begin
            dac_code_next = sar_pkg::WORD_ZERO;
        end else if (bit_step) begin
            dac_code_next = decided_word | lower_trial_word;
        end
    end

    // register the dac word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_code_reg <= sar_pkg::WORD_ZERO;
        end else begin
            dac_code_reg <= dac_code_next;
        end
    end

    // ======================================================================
    // output latches
    // ======================================================================

    // hold until a conversion completes, no pipeline delay
    always_comb begin
        result_next = result_reg;
        if (conv_done) begin
            result_next = decided_word;
        end
    end

    // register the latched result
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= sar_pkg::WORD_ZERO;
        end else begin
            result_reg <= result_next;
        end
    end

    // ======================================================================
    // busy status
    // ======================================================================

    // low from the accepted start, high again with the latched word
    always_comb begin
        busy_n_next = busy_n_reg;
        if (start_accept) begin
            busy_n_next = 1'b0;
        end else if (conv_done) begin
            busy_n_next = sar_pkg::BUSY_N_IDLE;
        end
    end

    // register busy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_n_reg <= sar_pkg::BUSY_N_IDLE;
        end else begin
            busy_n_reg <= busy_n_next;
        end
    end

    // ======================================================================
    // sampling switch
    // ======================================================================

    // hold both inputs at the start, reconnect them at completion
    always_comb begin
        track_next = track_reg;
        if (start_accept) begin
            track_next = 1'b0;
        end else if (conv_done) begin
            track_next = sar_pkg::TRACK_ON;
        end
    end

    // register the switch control
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            track_reg <= sar_pkg::TRACK_ON;
        end else begin
            track_reg <= track_next;
        end
    end

    // ======================================================================
    // outputs, all straight from flip-flops
    // ======================================================================
    assign busy_n      = busy_n_reg;
    assign result_data = result_reg;   // bit 13 result_msb, bit 0 result_lsb
    assign dac_code    = dac_code_reg;
    assign track       = track_reg;

endmodule

/* tb/comparator_model.sv */
// ==========================================================================
// comparator stand-in: decides each bit trial against a held target word
// ==========================================================================
module comparator_model (
    input  wire logic [sar_pkg::RESULT_WIDTH-1:0] dac_code,
    input  wire logic [sar_pkg::RESULT_WIDTH-1:0] target,
    output logic                                  cmp_keep
);
    timeunit 1ns;
    timeprecision 100ps;
    // keep the bit while the held input difference reaches the trial level
    assign cmp_keep = (target >= dac_code);
endmodule

/* tb/sar_conversion_sequencer_sva.sv */
// ==========================================================================
// port checker for the conversion sequencer
// ==========================================================================
module sar_conversion_sequencer_sva (
    input wire logic                              sys_clk,
    input wire logic                              rst_n,
    input wire logic                              conversion_start_n,
    input wire logic                              cmp_keep,
    input wire logic                              busy_n,
    input wire logic [sar_pkg::RESULT_WIDTH-1:0]  result_data,
    input wire logic [sar_pkg::RESULT_WIDTH-1:0]  dac_code,
    input wire logic                              track
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // conversion begins where busy drops
    sequence conv_begin;
        $fell(busy_n);
    endsequence
    // start request accepted from idle
    sequence start_idle;
        $past(conversion_start_n) && !conversion_start_n && busy_n;
    endsequence
    a_start_busy: assert property (start_idle |=> !busy_n)
        else $error("busy did not drop after start");
    a_busy_length: assert property (conv_begin |-> ##43 !busy_n ##1 busy_n)
        else $error("busy low time wrong");
    a_track_busy: assert property (track == busy_n)
        else $error("track differs from busy");
    a_dac_idle: assert property (busy_n |-> dac_code == 14'h0000)
        else $error("dac code not zero while idle");
    a_first_trial: assert property (conv_begin |=> dac_code == 14'h2000)
        else $error("first trial word wrong");
    a_msb_decide: assert property (conv_begin ##4 1 |=>
        dac_code == {$past(cmp_keep), 1'b1, 12'h000})
        else $error("msb decision wrong");
    a_lsb_trial: assert property (conv_begin ##42 1 |-> dac_code[0] == 1'b1)
        else $error("lsb trial missing");
    a_result_load: assert property ($rose(busy_n) |->
        result_data == {$past(dac_code[13:1]), $past(cmp_keep)})
        else $error("result not loaded at busy rise");
    a_result_hold: assert property (!$rose(busy_n) |-> $stable(result_data))
        else $error("result changed outside completion");
endmodule
bind sar_conversion_sequencer sar_conversion_sequencer_sva sar_conversion_sequencer_sva_i (.*);

/* tb/testbench.sv */
// ==========================================================================
// self-checking bench for the conversion sequencer
// ==========================================================================
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        conversion_start_n = 1'b1;
    logic        cmp_keep;
    logic        busy_n;
    logic [13:0] result_data;
    logic [13:0] dac_code;
    logic        track;
    logic [13:0] target = 14'h0000;
    int          errors = 0;
    int          n_compared = 0;
    always #4 sys_clk = ~sys_clk;
    sar_conversion_sequencer sar_conversion_sequencer_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .conversion_start_n(conversion_start_n), .cmp_keep(cmp_keep), .busy_n(busy_n),
        .result_data(result_data), .dac_code(dac_code), .track(track));
    comparator_model comparator_model_i (.dac_code(dac_code), .target(target),
        .cmp_keep(cmp_keep));
    // ======================================================================
    // shared compare and closing report
    // ======================================================================
    task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ======================================================================
    // scenarios
    // ======================================================================
    task automatic test_idle_state();
        check("busy_n", 14'h0001, {13'h0, busy_n});
        check("track", 14'h0001, {13'h0, track});
        check("dac_code", 14'h0000, dac_code);
        check("result_data", 14'h0000, result_data);
    endtask
    task automatic test_no_self_start();
        int low;
        low = 0;
        repeat (40) begin
            @(negedge sys_clk);
            if (busy_n !== 1'b1) low++;
        end
        check("self_start", 14'h0000, 14'(low));
    endtask
    task automatic run_conv(input logic [13:0] want, input logic [13:0] prev);
        int n;
        target = want;
        @(negedge sys_clk) conversion_start_n = 1'b0;
        @(negedge sys_clk);
        n = 0;
        while (busy_n === 1'b0 && n < 60) begin
            n++;
            @(negedge sys_clk);
            if (n == 5) conversion_start_n = 1'b1;
            if (n == 12) conversion_start_n = 1'b0;
            if (n == 16) conversion_start_n = 1'b1;
            if (n == 20) check("held result", prev, result_data);
        end
        if (n == 60) begin
            errors++;
            finish_test();
        end
        check("busy_low_cycles", 14'h002c, 14'(n));
        check("result_data", want, result_data);
        check("track", 14'h0001, {13'h0, track});
        repeat (sar_pkg::ACQ_MIN_CYCLES) @(negedge sys_clk);
    endtask
    task automatic test_conversions();
        logic [13:0] words [5] = '{14'h0000, 14'h3fff, 14'h2aaa, 14'h1555, 14'h2000};
        logic [13:0] prev;
        prev = 14'h0000;
        foreach (words[i]) begin
            run_conv(words[i], prev);
            prev = words[i];
        end
    endtask
    task automatic test_mid_reset();
        target = 14'h1234;
        @(negedge sys_clk) conversion_start_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b0;
        conversion_start_n = 1'b1;
        @(negedge sys_clk);
        test_idle_state();
        rst_n = 1'b1;
        run_conv(14'h0f0f, 14'h0000);
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        test_idle_state();
        rst_n = 1'b1;
        test_no_self_start();
        test_conversions();
        test_mid_reset();
        finish_test();
    end
endmodule
